// ---- logic/exvd_defines.vh ----
/*
 Shared constants of the exception vector dispatch block: register offsets,
 priority field positions, reset values and vector numbers.
 Assumes it is included by bare name from the logic/ directory.
*/
`ifndef EXVD_DEFINES_VH
`define EXVD_DEFINES_VH

// Register byte offsets on APB
`define EXVD_OFS_PRI_F      12'h000
`define EXVD_OFS_PRI_G      12'h004
`define EXVD_OFS_PRI_H      12'h008
`define EXVD_OFS_STATUS     12'h00c

// Reset value of every priority field
`define EXVD_PRI_RST        4'h0

// Priority field positions (low bit of each 4-bit field)
`define EXVD_F_SERIAL1_LSB  0
`define EXVD_G_CONV_LSB     12
`define EXVD_G_SOFT_LSB     8
`define EXVD_G_CMT0_LSB     4
`define EXVD_G_CMT1_LSB     0
`define EXVD_H_WDT_BSC_LSB  12
`define EXVD_H_PORT_OE_LSB  8

// Status register fields
`define EXVD_ST_VEC_LSB     0
`define EXVD_ST_LVL_LSB     8
`define EXVD_ST_BUSY_BIT    16
`define EXVD_ST_PEND_LSB    20

// Vector numbers
`define EXVD_VEC_POR_PC     8'h00
`define EXVD_VEC_POR_SP     8'h01
`define EXVD_VEC_MAN_PC     8'h02
`define EXVD_VEC_MAN_SP     8'h03
`define EXVD_VEC_GEN_ILL    8'h04
`define EXVD_VEC_SLOT_ILL   8'h06
`define EXVD_VEC_CPU_AE     8'h09
`define EXVD_VEC_DMA_AE     8'h0a
`define EXVD_VEC_NMI        8'h0b
`define EXVD_VEC_UBREAK     8'h0c
`define EXVD_VEC_TRAP_LO    8'h20
`define EXVD_VEC_TRAP_HI    8'h3f
`define EXVD_VEC_SER1_ERR   8'h84
`define EXVD_VEC_SER1_RXF   8'h85
`define EXVD_VEC_SER1_TXE   8'h86
`define EXVD_VEC_SER1_TEND  8'h87
`define EXVD_VEC_CONV0      8'h88
`define EXVD_VEC_CONV1      8'h89
`define EXVD_VEC_SOFT_TE    8'h8c
`define EXVD_VEC_CMT0       8'h90
`define EXVD_VEC_CMT1       8'h94
`define EXVD_VEC_WDT        8'h98
`define EXVD_VEC_BSC        8'h99
`define EXVD_VEC_PORT_OE    8'h9c

// Number of peripheral sources in the fixed default order
`define EXVD_NSRC           12

`endif

// ---- logic/exvd_arbiter.v ----
/*
 Level-based priority arbiter for peripheral interrupt sources, fixed order on equal levels.
 Assumes source 0 is the highest in the default order; all inputs are
 synchronous to the caller's clock, the logic is purely combinational.
*/
module exvd_arbiter #(
    parameter N  = 12,
    parameter LW = 4,
    parameter IW = 4
) (
    input  wire [N-1:0]    req,
    input  wire [N*LW-1:0] lvl_flat,
    output wire            found,
    output wire [IW-1:0]   win_idx,
    output wire [LW-1:0]   win_lvl
);

    wire [LW-1:0] best_lvl [0:N];
    wire [IW-1:0] best_idx [0:N];

    assign best_lvl[0] = {LW{1'b0}};
    assign best_idx[0] = {IW{1'b0}};

    // Strict compare: on equal level the earlier source keeps the win,
    // and a level of zero can never beat the starting value of zero
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_chain
            wire [31:0]   idx_w = i;
            wire [LW-1:0] lvl_i = lvl_flat[i*LW +: LW];
            wire          take  = req[i] && (lvl_i > best_lvl[i]);
            assign best_lvl[i+1] = take ? lvl_i : best_lvl[i];
            assign best_idx[i+1] = take ? idx_w[IW-1:0] : best_idx[i];
        end
    endgenerate

    assign found   = (best_lvl[N] != {LW{1'b0}});
    assign win_idx = best_idx[N];
    assign win_lvl = best_lvl[N];

endmodule // exvd_arbiter

// ---- logic/exvd_dispatch.v ----
/*
 Exception vector dispatch: holds the peripheral priority registers on APB,
 ranks pending exceptions and interrupts, and fetches vector table entries
 (reset PC and SP, or a service routine start address) for the core.
 Assumes one clock pclk, inputs synchronous to it, a memory port that answers
 a held fetch_req with fetch_ready, and a core that reloads its interrupt
 mask from dispatch_level after each interrupt dispatch.
*/
// The APB slave port and the register offsets were decided locally.
`include "exvd_defines.vh"

module exvd_dispatch #(
    parameter TWO_CONVERTERS = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        manual_reset_req,
    input  wire        illegal_general_req,
    input  wire        illegal_slot_req,
    input  wire        cpu_addr_err_req,
    input  wire        dma_addr_err_req,
    input  wire        nmi_req,
    input  wire        user_break_req,
    input  wire        trap_req,
    input  wire [7:0]  trap_imm,
    input  wire        serial1_receive_error_irq,
    input  wire        serial1_receive_full_irq,
    input  wire        serial1_transmit_empty_irq,
    input  wire        serial1_transmit_end_irq,
    input  wire        converter_done_irq_first,
    input  wire        converter_done_irq_second,
    input  wire        soft_transfer_end_irq,
    input  wire        compare_timer0_match_irq,
    input  wire        compare_timer1_match_irq,
    input  wire        watchdog_interval_irq,
    input  wire        bus_controller_match_irq,
    input  wire        port_output_enable_irq,
    input  wire [3:0]  cpu_int_mask,
    input  wire [31:0] vector_base,
    output wire        fetch_req,
    output wire [31:0] fetch_addr,
    input  wire        fetch_ready,
    input  wire [31:0] fetch_data,
    output wire        pc_load,
    output wire [31:0] pc_value,
    output wire        sp_load,
    output wire [31:0] sp_value,
    output wire        dispatch_done,
    output wire [7:0]  dispatch_vector,
    output wire [3:0]  dispatch_level,
    output wire        busy
);

    localparam NSRC = `EXVD_NSRC;

    localparam ST_IDLE = 2'd0;
    localparam ST_PC   = 2'd1;
    localparam ST_SP   = 2'd2;
    localparam ST_VEC  = 2'd3;

    // Pending bit positions of manual reset, exceptions, NMI and user break, highest first
    localparam P_MAN   = 0;
    localparam P_CPUAE = 1;
    localparam P_DMAAE = 2;
    localparam P_SLOT  = 3;
    localparam P_GEN   = 4;
    localparam P_TRAP  = 5;
    localparam P_NMI   = 6;
    localparam P_UBRK  = 7;
    localparam NPEND   = 8;

    reg  [15:0]      pri_f_r, pri_g_r, pri_h_r;
    reg  [31:0]      prdata_r;
    reg              rd_captured_r;
    reg  [1:0]       state_r, state_nxt;
    reg  [31:0]      fetch_addr_r, fetch_addr_nxt;
    reg  [31:0]      pc_value_r, sp_value_r;
    reg              pc_load_r, sp_load_r, done_r;
    reg  [7:0]       vec_r, vec_nxt;
    reg  [3:0]       lvl_r, lvl_nxt;
    reg  [NPEND-1:0] pend_r;
    reg  [NPEND-1:0] pend_clr;
    reg  [7:0]       trap_vec_r;
    reg  [31:0]      rd_mux;
    reg  [7:0]       irq_vec;

    wire             wr_en, mapped;
    wire [NPEND-1:0] pend_set;
    wire [NSRC-1:0]  irq_req;
    wire [NSRC*4-1:0] irq_lvl;
    wire             arb_found;
    wire [3:0]       arb_idx, arb_lvl;
    wire             irq_take, trap_ok;
    wire [7:0]       trap_vec_sel;

    // APB slave: reads are captured in the setup cycle, so both reads and
    // writes finish with no wait unless the clock enable holds them off
    assign mapped  = (paddr == `EXVD_OFS_PRI_F) || (paddr == `EXVD_OFS_PRI_G) ||
                     (paddr == `EXVD_OFS_PRI_H) || (paddr == `EXVD_OFS_STATUS);
    assign pready  = clk_en && (pwrite || rd_captured_r);
    assign pslverr = psel && penable && pready && !mapped;
    assign prdata  = prdata_r;
    assign wr_en   = psel && penable && pwrite && clk_en && mapped;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (paddr == `EXVD_OFS_PRI_F) begin
            rd_mux = {16'h0000, pri_f_r};
        end else if (paddr == `EXVD_OFS_PRI_G) begin
            rd_mux = {16'h0000, pri_g_r};
        end else if (paddr == `EXVD_OFS_PRI_H) begin
            rd_mux = {16'h0000, pri_h_r};
        end else if (paddr == `EXVD_OFS_STATUS) begin
            rd_mux[`EXVD_ST_VEC_LSB +: 8]     = vec_r;
            rd_mux[`EXVD_ST_LVL_LSB +: 4]     = lvl_r;
            rd_mux[`EXVD_ST_BUSY_BIT]         = busy;
            rd_mux[`EXVD_ST_PEND_LSB +: NPEND] = pend_r;
        end
    end

    // Only the documented priority fields exist; the other bits read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_f_r       <= 16'h0000;
            pri_g_r       <= 16'h0000;
            pri_h_r       <= 16'h0000;
            prdata_r      <= 32'h0000_0000;
            rd_captured_r <= 1'b0;
        end else if (clk_en) begin
            if (psel && !pwrite && !rd_captured_r) begin
                prdata_r <= rd_mux;
            end
            rd_captured_r <= psel && !pwrite && !(penable && rd_captured_r);
            if (wr_en && paddr == `EXVD_OFS_PRI_F) begin
                pri_f_r <= {12'h000, pwdata[`EXVD_F_SERIAL1_LSB +: 4]};
            end
            if (wr_en && paddr == `EXVD_OFS_PRI_G) begin
                pri_g_r <= pwdata[15:0];
            end
            if (wr_en && paddr == `EXVD_OFS_PRI_H) begin
                pri_h_r <= {pwdata[15:8], 8'h00};
            end
        end
    end

    // Peripheral sources in fixed default order, index 0 ranks highest
    assign irq_req = {port_output_enable_irq,
                      bus_controller_match_irq,
                      watchdog_interval_irq,
                      compare_timer1_match_irq,
                      compare_timer0_match_irq,
                      soft_transfer_end_irq,
                      converter_done_irq_second && (TWO_CONVERTERS != 0),
                      converter_done_irq_first,
                      serial1_transmit_end_irq,
                      serial1_transmit_empty_irq,
                      serial1_receive_full_irq,
                      serial1_receive_error_irq};

    assign irq_lvl = {pri_h_r[`EXVD_H_PORT_OE_LSB +: 4],
                      pri_h_r[`EXVD_H_WDT_BSC_LSB +: 4],
                      pri_h_r[`EXVD_H_WDT_BSC_LSB +: 4],
                      pri_g_r[`EXVD_G_CMT1_LSB +: 4],
                      pri_g_r[`EXVD_G_CMT0_LSB +: 4],
                      pri_g_r[`EXVD_G_SOFT_LSB +: 4],
                      pri_g_r[`EXVD_G_CONV_LSB +: 4],
                      pri_g_r[`EXVD_G_CONV_LSB +: 4],
                      {4{pri_f_r[`EXVD_F_SERIAL1_LSB +: 4]}}};

    exvd_arbiter #(
        .N  (NSRC),
        .LW (4),
        .IW (4)
    ) u_arb (
        .req      (irq_req),
        .lvl_flat (irq_lvl),
        .found    (arb_found),
        .win_idx  (arb_idx),
        .win_lvl  (arb_lvl)
    );

    // Only the listed numbers are ever produced, so reserved ones stay unused
    always @* begin
        case (arb_idx)
            4'h0:    irq_vec = `EXVD_VEC_SER1_ERR;
            4'h1:    irq_vec = `EXVD_VEC_SER1_RXF;
            4'h2:    irq_vec = `EXVD_VEC_SER1_TXE;
            4'h3:    irq_vec = `EXVD_VEC_SER1_TEND;
            4'h4:    irq_vec = `EXVD_VEC_CONV0;
            4'h5:    irq_vec = `EXVD_VEC_CONV1;
            4'h6:    irq_vec = `EXVD_VEC_SOFT_TE;
            4'h7:    irq_vec = `EXVD_VEC_CMT0;
            4'h8:    irq_vec = `EXVD_VEC_CMT1;
            4'h9:    irq_vec = `EXVD_VEC_WDT;
            4'ha:    irq_vec = `EXVD_VEC_BSC;
            default: irq_vec = `EXVD_VEC_PORT_OE;
        endcase
    end

    // The core's current mask still gates peripheral sources; NMI ignores it
    assign irq_take = arb_found && (arb_lvl > cpu_int_mask);

    // An immediate outside the user range would land on a reserved or
    // system vector, so it is turned into a general illegal instruction
    assign trap_ok      = (trap_imm >= `EXVD_VEC_TRAP_LO) && (trap_imm <= `EXVD_VEC_TRAP_HI);
    assign trap_vec_sel = trap_imm;

    assign pend_set = {user_break_req,
                       nmi_req,
                       trap_req && trap_ok,
                       illegal_general_req || (trap_req && !trap_ok),
                       illegal_slot_req,
                       dma_addr_err_req,
                       cpu_addr_err_req,
                       manual_reset_req};

    // Sequencer: picks the highest pending event when idle, then fetches
    always @* begin
        state_nxt      = state_r;
        fetch_addr_nxt = fetch_addr_r;
        vec_nxt        = vec_r;
        lvl_nxt        = lvl_r;
        pend_clr       = {NPEND{1'b0}};
        case (state_r)
            ST_IDLE: begin
                if (pend_r[P_MAN]) begin
                    pend_clr[P_MAN] = 1'b1;
                    vec_nxt         = `EXVD_VEC_MAN_PC;
                end else if (pend_r[P_CPUAE]) begin
                    pend_clr[P_CPUAE] = 1'b1;
                    vec_nxt           = `EXVD_VEC_CPU_AE;
                end else if (pend_r[P_DMAAE]) begin
                    pend_clr[P_DMAAE] = 1'b1;
                    vec_nxt           = `EXVD_VEC_DMA_AE;
                end else if (pend_r[P_SLOT]) begin
                    pend_clr[P_SLOT] = 1'b1;
                    vec_nxt          = `EXVD_VEC_SLOT_ILL;
                end else if (pend_r[P_GEN]) begin
                    pend_clr[P_GEN] = 1'b1;
                    vec_nxt         = `EXVD_VEC_GEN_ILL;
                end else if (pend_r[P_TRAP]) begin
                    pend_clr[P_TRAP] = 1'b1;
                    vec_nxt          = trap_vec_r;
                end else if (pend_r[P_NMI]) begin
                    pend_clr[P_NMI] = 1'b1;
                    vec_nxt         = `EXVD_VEC_NMI;
                    lvl_nxt         = 4'hf;
                end else if (pend_r[P_UBRK]) begin
                    pend_clr[P_UBRK] = 1'b1;
                    vec_nxt          = `EXVD_VEC_UBREAK;
                end else if (irq_take) begin
                    vec_nxt   = irq_vec;
                    lvl_nxt   = arb_lvl;
                end
                if (pend_clr[P_MAN]) begin
                    state_nxt      = ST_PC;
                    // Reset entries sit at the bottom of memory, not at the base
                    fetch_addr_nxt = {22'h000000, vec_nxt, 2'b00};
                end else if ((pend_clr != {NPEND{1'b0}}) || irq_take) begin
                    state_nxt      = ST_VEC;
                    fetch_addr_nxt = vector_base + {22'h000000, vec_nxt, 2'b00};
                end
            end
            ST_PC: begin
                if (fetch_ready) begin
                    fetch_addr_nxt = fetch_addr_r + 32'h0000_0004;
                    state_nxt      = ST_SP;
                end
            end
            default: begin
                if (fetch_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    assign fetch_req  = (state_r != ST_IDLE);
    assign fetch_addr = fetch_addr_r;
    assign busy       = (state_r != ST_IDLE);

    // Power-on reset starts the sequencer on the reset PC entry itself
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= ST_PC;
            fetch_addr_r <= 32'h0000_0000;
            vec_r        <= `EXVD_VEC_POR_PC;
            lvl_r        <= 4'h0;
            pend_r       <= {NPEND{1'b0}};
            trap_vec_r   <= `EXVD_VEC_TRAP_LO;
            pc_value_r   <= 32'h0000_0000;
            sp_value_r   <= 32'h0000_0000;
            pc_load_r    <= 1'b0;
            sp_load_r    <= 1'b0;
            done_r       <= 1'b0;
        end else if (clk_en) begin
            state_r      <= state_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            vec_r        <= vec_nxt;
            lvl_r        <= lvl_nxt;
            // A new event in the cycle its bit is taken stays pending
            pend_r       <= (pend_r & ~pend_clr) | pend_set;
            if (trap_req && trap_ok && !(pend_r[P_TRAP] && !pend_clr[P_TRAP])) begin
                trap_vec_r <= trap_vec_sel;
            end
            pc_load_r <= 1'b0;
            sp_load_r <= 1'b0;
            done_r    <= 1'b0;
            if (fetch_ready && (state_r == ST_PC || state_r == ST_VEC)) begin
                pc_value_r <= fetch_data;
            end
            if (fetch_ready && state_r == ST_VEC) begin
                pc_load_r <= 1'b1;
                done_r    <= 1'b1;
            end
            if (fetch_ready && state_r == ST_SP) begin
                // PC and SP are handed over together once both are in
                sp_value_r <= fetch_data;
                pc_load_r  <= 1'b1;
                sp_load_r  <= 1'b1;
                done_r     <= 1'b1;
            end
        end
    end

    assign pc_load         = pc_load_r;
    assign pc_value        = pc_value_r;
    assign sp_load         = sp_load_r;
    assign sp_value        = sp_value_r;
    assign dispatch_done   = done_r;
    assign dispatch_vector = vec_r;
    assign dispatch_level  = lvl_r;

endmodule // exvd_dispatch

// ---- verification/exvd_dispatch_properties.sv ----
/*
 Concurrent checks on the ports of exvd_dispatch: fetch handshake, reset
 and exception vectors, table addressing and the APB answer.
 Assumes clk_en is held high and cpu_int_mask is steady during a dispatch.
*/
module exvd_dispatch_properties (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  cpu_int_mask,
    input wire [31:0] vector_base,
    input wire        fetch_req,
    input wire [31:0] fetch_addr,
    input wire        fetch_ready,
    input wire        pc_load,
    input wire        sp_load,
    input wire        dispatch_done,
    input wire [7:0]  dispatch_vector,
    input wire [3:0]  dispatch_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_taken;
        fetch_req && fetch_ready;
    endsequence
    sequence s_last_fetch;
        s_taken ##1 !fetch_req;
    endsequence
    a_fetch_held: assert property (fetch_req && !fetch_ready |=> fetch_req && $stable(fetch_addr))
        else $error("fetch request dropped or moved");
    a_last_fetch_loads: assert property (s_last_fetch |-> dispatch_done && pc_load)
        else $error("completed fetch not loaded");
    a_done_has_cause: assert property (dispatch_done |-> $past(fetch_req && fetch_ready))
        else $error("done without a fetch");
    a_sp_from_reset: assert property (sp_load |-> $past(fetch_addr) inside {32'h4, 32'hc})
        else $error("stack pointer from wrong entry");
    a_entry_addr_calc: assert property (dispatch_done && !sp_load |->
        $past(fetch_addr) == $past(vector_base) + {22'h0, dispatch_vector, 2'b00})
        else $error("entry address mismatch");
    a_no_reserved_vec: assert property (dispatch_done |->
        !(dispatch_vector inside {8'h05, 8'h07, 8'h08, [8'h0d:8'h1f]}))
        else $error("reserved vector used");
    a_irq_above_mask: assert property (dispatch_done && dispatch_vector >= 8'h84 |->
        dispatch_level > cpu_int_mask && dispatch_level != 4'h0)
        else $error("masked interrupt taken");
    a_apb_unmapped_err: assert property (psel && penable && pready |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("slave error mismatch");
    a_apb_write_now: assert property (psel && penable && pwrite |-> pready)
        else $error("write not answered at once");
endmodule // exvd_dispatch_properties

// ---- verification/exvd_mem_model.sv ----
/*
 Vector table memory on the fetch port: answers after 1 to 4 cycles.
 Assumes fetch_req and fetch_addr are held until fetch_ready.
*/
module exvd_mem_model #(
    parameter logic [31:0] KEY = 32'h5a5a0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ready,
    output logic [31:0]      fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rnd_r;
    logic [1:0]  wait_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_ready <= 1'b0;
            wait_r      <= 2'h0;
            rnd_r       <= 32'h1d872b41;
        end else begin
            rnd_r <= {rnd_r[30:0], rnd_r[31] ^ rnd_r[21] ^ rnd_r[1] ^ rnd_r[0]};
            if (fetch_ready) begin
                fetch_ready <= 1'b0;
                wait_r      <= rnd_r[1:0];
            end else if (fetch_req) begin
                if (wait_r == 2'h0)
                    fetch_ready <= 1'b1;
                else
                    wait_r <= wait_r - 2'h1;
            end
        end
    end
    // Entry content follows its address; garbage outside the answer cycle
    assign fetch_data = fetch_ready ? fetch_addr ^ KEY : ~(fetch_addr ^ KEY) ^ rnd_r;
endmodule // exvd_mem_model

// ---- verification/exvd_dispatch_tb.sv ----
/*
 Self-checking bench for exvd_dispatch: reset fetch, exceptions, traps,
 priority registers over APB and peripheral arbitration.
 Assumes exvd_mem_model answers fetches; clk_en is tied high.
*/
module exvd_dispatch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] KEY = 32'h5a5a0000;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [11:0] paddr = 12'h000, irq = 12'h000;
    logic [31:0] pwdata = 32'h0, vector_base = 32'h0, lfsr = 32'h761b29a2, rd, base;
    logic [7:0]  exc = 8'h00, trap_imm = 8'h00, imm, exp;
    logic [3:0]  cpu_int_mask = 4'h0;
    logic [7:0]  ev [9] = '{8'h02, 8'h04, 8'h06, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h00, 8'h04};
    logic [7:0]  iv [12] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h99, 8'h9c};
    wire  [31:0] prdata, fetch_addr, fetch_data, pc_value, sp_value;
    wire         pready, pslverr, fetch_req, fetch_ready, pc_load, sp_load, dispatch_done, busy;
    wire  [7:0]  dispatch_vector;
    wire  [3:0]  dispatch_level;
    int          errors = 0, n_checks = 0;
    always #2.5 pclk = ~pclk;

    exvd_dispatch dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .manual_reset_req(exc[0]), .illegal_general_req(exc[1]),
        .illegal_slot_req(exc[2]), .cpu_addr_err_req(exc[3]), .dma_addr_err_req(exc[4]),
        .nmi_req(exc[5]), .user_break_req(exc[6]), .trap_req(exc[7]), .trap_imm,
        .serial1_receive_error_irq(irq[0]), .serial1_receive_full_irq(irq[1]),
        .serial1_transmit_empty_irq(irq[2]), .serial1_transmit_end_irq(irq[3]),
        .converter_done_irq_first(irq[4]), .converter_done_irq_second(irq[5]),
        .soft_transfer_end_irq(irq[6]), .compare_timer0_match_irq(irq[7]),
        .compare_timer1_match_irq(irq[8]), .watchdog_interval_irq(irq[9]),
        .bus_controller_match_irq(irq[10]), .port_output_enable_irq(irq[11]), .cpu_int_mask,
        .vector_base, .fetch_req, .fetch_addr, .fetch_ready, .fetch_data, .pc_load, .pc_value,
        .sp_load, .sp_value, .dispatch_done, .dispatch_vector, .dispatch_level, .busy);
    exvd_mem_model #(.KEY(KEY)) u_mem (.pclk, .presetn, .fetch_req, .fetch_addr, .fetch_ready, .fetch_data);

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] mem(input logic [31:0] a);
        return a ^ KEY;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
        n_checks++;
        if (got !== want) begin
            errors++;
            $display("[ERR] %0t %s got %h want %h", $time, m, got, want);
        end
    endtask
    // Values are read right after the edge, before that edge's updates land
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (dispatch_done === 1'b1) return;
        end
        chk(0, 1, "no dispatch");
    endtask
    // Not acknowledged by the block, so a still-high source may repeat once
    task automatic irq_case(input logic [15:0] f, g, h, input logic [11:0] src, input logic [7:0] v);
        logic hit;
        apb(1'b1, 12'h000, {16'h0, f});
        apb(1'b1, 12'h004, {16'h0, g});
        apb(1'b1, 12'h008, {16'h0, h});
        irq <= src;
        hit = 1'b0;
        for (int i = 0; i < 30 && !hit; i++) begin
            @(posedge pclk);
            hit = (dispatch_done === 1'b1);
        end
        chk({hit, hit ? dispatch_vector : 8'h00}, {v != 8'h00, v}, "irq vector");
        irq <= 12'h000;
        repeat (16) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #50000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_done();
        chk(pc_value, mem(32'h0), "por pc");
        chk(sp_value, mem(32'h4), "por sp");
        for (int a = 0; a < 3; a++) begin
            apb(1'b0, 12'(a * 4), 32'h0);
            chk(rd, 32'h0, "prio reset");
            apb(1'b1, 12'(a * 4), lfsr);
            apb(1'b0, 12'(a * 4), 32'h0);
            chk(rd, lfsr & (a == 0 ? 32'h000f : a == 1 ? 32'hffff : 32'hff00), "prio rw");
            lfsr = nxt(lfsr);
        end
        apb(1'b1, 12'h00c, 32'hffffffff);
        chk({31'h0, e}, 32'h0, "status write");
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], e}, 32'h1, "unmapped");
        for (int k = 0; k < 9; k++) begin
            base = (k == 0) ? 32'h0 : {lfsr[31:12], 12'h000};
            imm = (k == 8) ? 8'h40 : {3'b001, lfsr[4:0]};
            vector_base <= {lfsr[31:12], 12'h000};
            trap_imm <= imm;
            exc <= 8'h01 << (k > 7 ? 7 : k);
            lfsr = nxt(lfsr);
            @(posedge pclk);
            exc <= 8'h00;
            wait_done();
            exp = (k == 7) ? imm : ev[k];
            chk({24'h0, dispatch_vector}, {24'h0, exp}, "vector");
            chk(pc_value, mem(base + {22'h0, exp, 2'b00}), "entry");
            chk({31'h0, busy}, 32'h0, "busy after done");
            if (k == 5) chk({28'h0, dispatch_level}, 32'hf, "nmi level");
            if (k == 0) chk(sp_value, mem(32'hc), "manual sp");
        end
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0000_0f04, "status");
        for (int k = 0; k < 12; k++)
            irq_case(16'h1, 16'h1111, 16'h1100, 12'h001 << k, iv[k]);
        irq_case(16'h1, 16'h1111, 16'h1100, 12'h00f, 8'h84);
        irq_case(16'h1, 16'h1111, 16'h1100, 12'h030, 8'h88);
        irq_case(16'h1, 16'h1111, 16'h1100, 12'h600, 8'h98);
        irq_case(16'h1, 16'h1112, 16'h1100, 12'h101, 8'h94);
        irq_case(16'h1, 16'h2111, 16'h1100, 12'h011, 8'h88);
        irq_case(16'h1, 16'h1211, 16'h1100, 12'h0c0, 8'h8c);
        irq_case(16'h1, 16'h1121, 16'h1100, 12'h0c0, 8'h90);
        irq_case(16'h1, 16'h1111, 16'h1200, 12'ha00, 8'h9c);
        cpu_int_mask <= 4'h1;
        irq_case(16'h1, 16'h1112, 16'h1100, 12'h001, 8'h00);
        irq_case(16'h1, 16'h1112, 16'h1100, 12'h101, 8'h94);
        cpu_int_mask <= 4'h0;
        irq_case(16'h0, 16'h1111, 16'h1100, 12'h001, 8'h00);
        tally_and_finish();
    end
endmodule // exvd_dispatch_tb

bind exvd_dispatch exvd_dispatch_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pready, .pslverr, .cpu_int_mask, .vector_base, .fetch_req, .fetch_addr, .fetch_ready, .pc_load,
    .sp_load, .dispatch_done, .dispatch_vector, .dispatch_level);
